// *** hw/asp_core.sv ***
/*
 Asynchronous NRZ serial port: registers, flag clearing, transmitter and 16x receiver.
 Assumes a plain register port on mclk_i; rxd_i and txd_i are asynchronous pins.
*/
`timescale 1ns/1ps
`default_nettype none
module asp_core (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [asp_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic rxd_i,
  input wire logic txd_i,
  output logic txd_o,
  output logic txd_oe_o
);
  logic [12:0] baud_q;
  logic [15:0] opt_q;
  logic [8:0] stat_q;
  logic [8:0] arm_q;
  logic [1:0] pin_q;
  logic [8:0] rdr_q;
  logic [8:0] tdr_q;
  logic tick;
  logic nine, pen, podd, rx_en, tx_en;

  assign nine = opt_q[asp_pkg::OPT_NINE];
  assign pen = opt_q[asp_pkg::OPT_PEN];
  assign podd = opt_q[asp_pkg::OPT_PODD];
  assign rx_en = opt_q[asp_pkg::OPT_RXEN];
  assign tx_en = opt_q[asp_pkg::OPT_TXEN];

  asp_baud_gen #(.DIV_W(asp_pkg::DIV_W)) u_baud (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .div_i(baud_q),
    .tick_o(tick)
  );

  // Pin synchronisers
  logic rxd_s1_q, rxd_s2_q, txi_s1_q, txi_s2_q;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rxd_s1_q <= 1'b1;
      rxd_s2_q <= 1'b1;
      txi_s1_q <= 1'b1;
      txi_s2_q <= 1'b1;
    end else begin
      rxd_s1_q <= rxd_i;
      rxd_s2_q <= rxd_s1_q;
      txi_s1_q <= txd_i;
      txi_s2_q <= txi_s1_q;
    end
  end

  // Bus decode
  logic wr_baud, wr_opt, wr_data, wr_pin, rd_stat, rd_data, rd_long;
  assign wr_baud = wr_i && addr_i == asp_pkg::OFF_BAUD;
  assign wr_opt = wr_i && addr_i == asp_pkg::OFF_OPT;
  assign wr_data = wr_i && addr_i == asp_pkg::OFF_DATA;
  assign wr_pin = wr_i && addr_i == asp_pkg::OFF_PIN;
  assign rd_stat = rd_i && addr_i == asp_pkg::OFF_STAT;
  assign rd_data = rd_i && addr_i == asp_pkg::OFF_DATA;
  assign rd_long = rd_i && addr_i == asp_pkg::OFF_LONG;

  // ---------------- Receiver ----------------
  asp_pkg::asp_rx_state_t rx_st_q;
  logic [3:0] ph_q;
  logic [3:0] rbit_q;
  logic [8:0] rsh_q;
  logic [1:0] hi_q;
  logic [2:0] smp_q;
  logic prev_q;
  logic noise_q;
  logic bit_val, bit_noisy, rx_done, rx_fe;
  logic [2:0] smp_all;
  logic [8:0] rx_word;
  logic rx_msb;

  assign smp_all = {rxd_s2_q, smp_q[1:0]};
  assign bit_val = (smp_all[0] & smp_all[1]) | (smp_all[0] & smp_all[2]) | (smp_all[1] & smp_all[2]);
  assign bit_noisy = !(&smp_all) && (|smp_all);
  assign rx_word = nine ? rsh_q : {1'b0, rsh_q[8:1]};
  assign rx_msb = nine ? rx_word[8] : rx_word[7];
  assign rx_done = tick && rx_st_q == asp_pkg::ASP_RX_STOP && ph_q == asp_pkg::PH_S2;
  assign rx_fe = !bit_val;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_st_q <= asp_pkg::ASP_RX_IDLE;
      ph_q <= '0;
      rbit_q <= '0;
      rsh_q <= '0;
      hi_q <= '0;
      smp_q <= '0;
      prev_q <= 1'b1;
      noise_q <= 1'b0;
    end else if (!rx_en) begin
      rx_st_q <= asp_pkg::ASP_RX_IDLE;
      hi_q <= '0;
      prev_q <= 1'b1;
    end else if (tick) begin
      prev_q <= rxd_s2_q;
      if (ph_q >= asp_pkg::PH_S0 && ph_q < asp_pkg::PH_S2) begin
        smp_q <= {smp_q[1:0], rxd_s2_q};
      end
      case (rx_st_q)
        asp_pkg::ASP_RX_IDLE: begin
          if (rxd_s2_q) begin
            hi_q <= (hi_q == asp_pkg::START_HIGH_MIN) ? hi_q : hi_q + 2'h1;
          end else begin
            hi_q <= '0;
            if (prev_q && hi_q == asp_pkg::START_HIGH_MIN) begin
              rx_st_q <= asp_pkg::ASP_RX_START;
              ph_q <= 4'h1;
              noise_q <= 1'b0;
            end
          end
        end
        default: begin
          // Realign on an edge seen away from the sampling window
          if (rxd_s2_q != prev_q && (ph_q < 4'h5 || ph_q > 4'hb)) begin
            ph_q <= 4'h1;
          end else begin
            ph_q <= (ph_q == asp_pkg::PH_LAST) ? 4'h0 : ph_q + 4'h1;
          end
          if (ph_q == asp_pkg::PH_S2) begin
            noise_q <= noise_q | bit_noisy;
            case (rx_st_q)
              asp_pkg::ASP_RX_START: begin
                if (bit_val) begin
                  rx_st_q <= asp_pkg::ASP_RX_IDLE;
                  hi_q <= '0;
                end else begin
                  rx_st_q <= asp_pkg::ASP_RX_DATA;
                  rbit_q <= '0;
                end
              end
              asp_pkg::ASP_RX_DATA: begin
                rsh_q <= {bit_val, rsh_q[8:1]};
                rbit_q <= rbit_q + 4'h1;
                if (rbit_q == (nine ? 4'h8 : 4'h7)) begin
                  rx_st_q <= asp_pkg::ASP_RX_STOP;
                end
              end
              default: begin
                rx_st_q <= asp_pkg::ASP_RX_IDLE;
                hi_q <= bit_val ? asp_pkg::START_HIGH_MIN : 2'h0;
              end
            endcase
          end
        end
      endcase
    end
  end

  // Wakeup: frames are dropped until one arrives with its top bit set
  logic rx_accept, rwu_clr;
  assign rwu_clr = rx_done && opt_q[asp_pkg::OPT_RWU] && rx_msb;
  assign rx_accept = rx_done && (!opt_q[asp_pkg::OPT_RWU] || rx_msb);

  // ---------------- Transmitter ----------------
  logic [10:0] tsh_q;
  logic [3:0] tcnt_q;
  logic [3:0] tph_q;
  logic tx_on_q;
  logic pre_q;
  logic txen_prev_q;
  logic bit_end, slot_free, load_pre, load_brk, load_dat, tx_quiet;
  logic [8:0] tx_field;
  logic par_bit;

  assign bit_end = tick && tph_q == asp_pkg::PH_LAST;
  assign slot_free = tick && tcnt_q == '0 && tx_on_q;
  assign load_pre = slot_free && tx_en && pre_q;
  assign load_brk = slot_free && tx_en && !pre_q && opt_q[asp_pkg::OPT_BRK];
  assign load_dat = slot_free && tx_en && !pre_q && !opt_q[asp_pkg::OPT_BRK] && !stat_q[asp_pkg::ST_TRANSMIT_EMPTY_FLAG];
  assign tx_quiet = slot_free && !load_pre && !load_brk && !load_dat;
  // Parity over the data bits below the top position
  assign par_bit = podd ^ (nine ? ^tdr_q[7:0] : ^tdr_q[6:0]);
  always_comb begin
    if (nine) begin
      tx_field = {pen ? par_bit : tdr_q[8], tdr_q[7:0]};
    end else begin
      tx_field = {1'b1, pen ? par_bit : tdr_q[7], tdr_q[6:0]};
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tsh_q <= '1;
      tcnt_q <= '0;
      tph_q <= '0;
      tx_on_q <= 1'b0;
      pre_q <= 1'b0;
      txen_prev_q <= 1'b0;
    end else begin
      txen_prev_q <= tx_en;
      if (tx_en && !txen_prev_q) begin
        tx_on_q <= 1'b1;
        pre_q <= 1'b1;
      end else if (load_pre) begin
        pre_q <= 1'b0;
      end
      if (load_pre) begin
        tsh_q <= '1;
      end else if (load_brk) begin
        tsh_q <= '0;
      end else if (load_dat) begin
        tsh_q <= {1'b1, tx_field, 1'b0};
      end else if (bit_end && tcnt_q != '0) begin
        tsh_q <= {1'b1, tsh_q[10:1]};
      end
      if (load_pre || load_brk || load_dat) begin
        tcnt_q <= nine ? asp_pkg::LEN_LONG : asp_pkg::LEN_SHORT;
        tph_q <= '0;
      end else if (tick && tcnt_q != '0) begin
        tph_q <= (tph_q == asp_pkg::PH_LAST) ? 4'h0 : tph_q + 4'h1;
        if (bit_end) begin
          tcnt_q <= tcnt_q - 4'h1;
        end
      end
      if (tx_quiet && !tx_en) begin
        tx_on_q <= 1'b0;
      end
    end
  end

  // Pin steering
  assign txd_o = (tx_on_q || tx_en) ? (tcnt_q == '0 ? 1'b1 : tsh_q[0]) : pin_q[asp_pkg::PIN_VAL];
  assign txd_oe_o = tx_on_q | tx_en | pin_q[asp_pkg::PIN_DIR];

  // ---------------- Status flags ----------------
  logic [8:0] st_set, st_clr;
  always_comb begin
    st_set = '0;
    st_set[asp_pkg::ST_TRANSMIT_EMPTY_FLAG] = load_dat;
    st_set[asp_pkg::ST_TC] = tx_quiet && !opt_q[asp_pkg::OPT_BRK];
    if (rx_accept) begin
      if (stat_q[asp_pkg::ST_RDRF]) begin
        st_set[asp_pkg::ST_OR] = 1'b1;
      end else begin
        st_set[asp_pkg::ST_RDRF] = 1'b1;
        st_set[asp_pkg::ST_FE] = rx_fe;
        st_set[asp_pkg::ST_NF] = noise_q | bit_noisy;
        st_set[asp_pkg::ST_PF] = pen && ((^rx_word) != podd);
      end
    end
    st_clr = '0;
    if (rd_data || wr_data) begin
      st_clr = arm_q;
    end
    if (rd_long) begin
      st_clr = stat_q & ~asp_pkg::ST_TXBITS;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      stat_q <= asp_pkg::ST_RST;
    end else begin
      // New events win over a clear in the same cycle
      stat_q <= ((stat_q & ~st_clr) | st_set) & asp_pkg::ST_MASK;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      arm_q <= '0;
    end else if (rd_stat) begin
      arm_q <= stat_q;
    end else if (rd_data || wr_data || rd_long) begin
      arm_q <= '0;
    end
  end

  // ---------------- Data holding registers ----------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdr_q <= '0;
    end else if (rx_accept && !stat_q[asp_pkg::ST_RDRF]) begin
      rdr_q <= rx_word;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tdr_q <= '0;
    end else if (wr_data) begin
      tdr_q <= nine ? wdata_i[8:0] : {1'b0, wdata_i[7:0]};
    end
  end

  // ---------------- Control registers ----------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      baud_q <= asp_pkg::BAUD_RST;
    end else if (wr_baud) begin
      baud_q <= wdata_i[12:0];
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      opt_q <= asp_pkg::OPT_RST;
    end else if (wr_opt) begin
      opt_q <= wdata_i[15:0] & asp_pkg::OPT_MASK;
    end else if (rwu_clr) begin
      opt_q[asp_pkg::OPT_RWU] <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pin_q <= asp_pkg::PIN_RST;
    end else if (wr_pin) begin
      pin_q <= wdata_i[1:0];
    end
  end

  // ---------------- Read data ----------------
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      case (addr_i)
        asp_pkg::OFF_BAUD: rdata_o <= {19'h0, baud_q};
        asp_pkg::OFF_OPT: rdata_o <= {16'h0, opt_q};
        asp_pkg::OFF_STAT: rdata_o <= {23'h0, stat_q};
        asp_pkg::OFF_DATA: rdata_o <= {23'h0, rdr_q};
        asp_pkg::OFF_LONG: rdata_o <= {7'h0, stat_q, 7'h0, rdr_q};
        asp_pkg::OFF_PIN: rdata_o <= {29'h0, txi_s2_q, pin_q};
        default: rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end
endmodule // asp_core
`default_nettype wire

// *** hw/asp_pkg.sv ***
/*
 Constants, register map and state encodings for the asynchronous serial port core.
 Assumes a 16-bit register set reached on a 32-bit word-aligned plain port.
*/
package asp_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DIV_W = 13;
  localparam logic [4:0] OFF_BAUD = 5'h00;
  localparam logic [4:0] OFF_OPT = 5'h04;
  localparam logic [4:0] OFF_STAT = 5'h08;
  localparam logic [4:0] OFF_DATA = 5'h0c;
  localparam logic [4:0] OFF_LONG = 5'h10;
  localparam logic [4:0] OFF_PIN = 5'h14;
  // option_control fields
  localparam int unsigned OPT_BRK = 0;
  localparam int unsigned OPT_RWU = 1;
  localparam int unsigned OPT_RXEN = 2;
  localparam int unsigned OPT_TXEN = 3;
  localparam int unsigned OPT_NINE = 8;
  localparam int unsigned OPT_PODD = 9;
  localparam int unsigned OPT_PEN = 10;
  localparam logic [15:0] OPT_MASK = 16'h070f;
  // serial_status fields
  localparam int unsigned ST_PF = 0;
  localparam int unsigned ST_FE = 1;
  localparam int unsigned ST_NF = 2;
  localparam int unsigned ST_OR = 3;
  localparam int unsigned ST_RDRF = 6;
  localparam int unsigned ST_TC = 7;
  localparam int unsigned ST_TRANSMIT_EMPTY_FLAG = 8;
  localparam logic [8:0] ST_MASK = 9'h1cf;
  localparam logic [8:0] ST_TXBITS = 9'h180;
  // pin_assignment_register fields
  localparam int unsigned PIN_VAL = 0;
  localparam int unsigned PIN_DIR = 1;
  localparam int unsigned PIN_IN = 2;
  // Reset values
  localparam logic [12:0] BAUD_RST = 13'h0000;
  localparam logic [15:0] OPT_RST = 16'h0000;
  localparam logic [8:0] ST_RST = 9'h180;
  localparam logic [1:0] PIN_RST = 2'h0;
  // Timing in system clocks and sample ticks
  localparam int unsigned CLK_PER_TICK = 2;
  localparam int unsigned OVERSAMPLE = 16;
  localparam logic [3:0] PH_LAST = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] PH_S0 = 4'h7;
  localparam logic [3:0] PH_S2 = 4'h9;
  localparam logic [1:0] START_HIGH_MIN = 2'h3;
  localparam logic [3:0] LEN_SHORT = 4'ha;
  localparam logic [3:0] LEN_LONG = 4'hb;

  typedef enum logic [1:0] {
    ASP_RX_IDLE = 2'b00,
    ASP_RX_START = 2'b01,
    ASP_RX_DATA = 2'b10,
    ASP_RX_STOP = 2'b11
  } asp_rx_state_t;
endpackage

// *** hw/asp_baud_gen.sv ***
/*
 Rate divider producing the 16x receive sampling tick.
 Assumes one system clock; a zero divider stops the generator.
*/
`timescale 1ns/1ps
`default_nettype none
module asp_baud_gen #(
  parameter int unsigned DIV_W = 13
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [DIV_W-1:0] div_i,
  output logic tick_o
);
  logic [DIV_W:0] cnt_q;
  logic [DIV_W:0] limit;

  // One tick every 2*div clocks: bit rate = clk / (32*div)
  assign limit = (DIV_W+1)'(asp_pkg::CLK_PER_TICK) * {1'b0, div_i} - (DIV_W+1)'(1);

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end else if (div_i == '0) begin
      cnt_q <= '0;
      tick_o <= 1'b0;
    end else if (cnt_q >= limit) begin
      cnt_q <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + (DIV_W+1)'(1);
      tick_o <= 1'b0;
    end
  end
endmodule // asp_baud_gen
`default_nettype wire

// *** verif/asp_core_chk.sv ***
/*
 Port checker for asp_core, bound to its top.
 Assumes software reaches divider, option and pin registers only through the plain port.
*/
`timescale 1ns/1ps
`default_nettype none
module asp_core_chk (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [asp_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic rxd_i,
  input wire logic txd_i,
  input wire logic txd_o,
  input wire logic txd_oe_o
);
  logic txen_q, used_q, dir_q, val_q;
  logic [12:0] div_q;
  logic [15:0] low_q;
  // Shadow of transmitter enable
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      txen_q <= 1'b0;
      used_q <= 1'b0;
    end else if (wr_i && addr_i == asp_pkg::OFF_OPT) begin
      txen_q <= wdata_i[asp_pkg::OPT_TXEN];
      used_q <= used_q | wdata_i[asp_pkg::OPT_TXEN];
    end
  end
  // Shadow of divider and pin settings
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q <= 13'h0000;
      dir_q <= 1'b0;
      val_q <= 1'b0;
    end else if (wr_i && addr_i == asp_pkg::OFF_BAUD) begin
      div_q <= wdata_i[12:0];
    end else if (wr_i && addr_i == asp_pkg::OFF_PIN) begin
      dir_q <= wdata_i[asp_pkg::PIN_DIR];
      val_q <= wdata_i[asp_pkg::PIN_VAL];
    end
  end
  // Length of the current low run on the driven pin
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) low_q <= 16'h0000;
    else if (txd_oe_o && !txd_o) low_q <= low_q + 16'h0001;
    else low_q <= 16'h0000;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  a_rdata_idle_zero: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("read data outside its slot");
  a_unmapped_read_zero: assert property (rd_i && addr_i == 5'h18 |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_status_unused_zero: assert property (rd_i && addr_i == asp_pkg::OFF_STAT |=>
    rdata_o[31:9] == 23'h0 && rdata_o[5:4] == 2'h0) else $error("status unused bits set");
  a_data_upper_zero: assert property (rd_i && addr_i == asp_pkg::OFF_DATA |=>
    rdata_o[31:9] == 23'h0) else $error("data upper bits set");
  a_long_read_layout: assert property (rd_i && addr_i == asp_pkg::OFF_LONG |=>
    rdata_o[31:25] == 7'h0 && rdata_o[15:9] == 7'h0) else $error("long read layout");
  a_tx_owns_pin: assert property (txen_q |-> txd_oe_o) else $error("pin not driven by transmitter");
  a_gpio_pin_drive: assert property (!used_q |-> txd_oe_o == dir_q && (!dir_q || txd_o == val_q))
    else $error("pin not following gpio");
  a_zero_div_still: assert property (div_q == 13'h0 && $past(div_q) == 13'h0 && !wr_i |=>
    $stable(txd_o)) else $error("pin moved with divider zero");
  a_bit_time_len: assert property (txen_q && $past(txen_q) && div_q == 13'h1 && $rose(txd_o) |->
    low_q[4:0] == 5'h0) else $error("low run not whole bit times");
endmodule // asp_core_chk
bind asp_core asp_core_chk asp_core_chk_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd_i), .txd_i(txd_i),
  .txd_o(txd_o), .txd_oe_o(txd_oe_o));
`default_nettype wire

// *** verif/asp_remote.sv ***
/*
 Remote serial transceiver: sends frames on the receive line, captures frames off the transmit line.
 Assumes BIT_CLKS system clocks per bit, which is 32 at divider 1.
*/
`timescale 1ns/1ps
`default_nettype none
module asp_remote #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk_i,
  input wire logic line_i,
  output logic rxd_o
);
  initial rxd_o = 1'b1;
  // Frame bits go out from bit 0 upward
  task automatic send(input logic [11:0] bits, input int n);
    repeat (BIT_CLKS) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      rxd_o <= bits[i];
      repeat (BIT_CLKS) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
  endtask
  // Samples mid-bit from the first falling edge
  task automatic grab(output logic [11:0] bits, input int n);
    bits = 12'h000;
    @(negedge line_i);
    repeat (BIT_CLKS / 2) @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      bits[i] = line_i;
      repeat (BIT_CLKS) @(posedge clk_i);
    end
  endtask
endmodule // asp_remote
`default_nettype wire

// *** verif/tb.sv ***
/*
 Testbench for asp_core with a flag model and a remote transceiver.
 Assumes a pull-up on the transmit pin and divider 1 for every frame.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk_i, rst_b_i, wr_i, rd_i, rxd, txd_o, txd_oe_o;
  logic [4:0] addr_i;
  logic [31:0] wdata_i, rdata_o, v, e;
  logic [8:0] d;
  logic [11:0] f;
  int fail_count, tests_run, seed, st, arm;
  wire logic txd_w = txd_oe_o ? txd_o : 1'b1;
  asp_core asp_core_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_i(rxd), .txd_i(txd_w), .txd_o(txd_o),
    .txd_oe_o(txd_oe_o));
  asp_remote asp_remote_inst (.clk_i(mclk_i), .line_i(txd_w), .rxd_o(rxd));
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] x);
    addr_i <= a;
    wdata_i <= {16'h0000, x};
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    @(posedge mclk_i);
    if (a == asp_pkg::OFF_DATA) st = st & ~arm;
    if (a == asp_pkg::OFF_DATA) arm = 0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    @(negedge mclk_i);
    q = rdata_o;
    @(posedge mclk_i);
    if (a == asp_pkg::OFF_DATA) st = st & ~arm;
    if (a == asp_pkg::OFF_LONG) st = st & 'h180;
    if (a == asp_pkg::OFF_DATA || a == asp_pkg::OFF_LONG) arm = 0;
  endtask
  task automatic rd_stat(input int mask);
    rd(asp_pkg::OFF_STAT, v);
    chk(v & mask, st & mask);
    arm = st;
  endtask
  task automatic rx(input int nb, input int pen, input int podd, input int bad, input int en);
    d = 9'($random(seed));
    if (nb == 8) d[8] = 1'b0;
    if (pen != 0) d[nb-1] = 1'b0;
    if (pen != 0) d[nb-1] = ^d ^ podd[0] ^ bad[0];
    f = {2'h3, d, 1'b0};
    f[nb+1] = 1'b1;
    asp_remote_inst.send(f, nb + 2);
    if (en != 0) st = st | 'h40 | ((pen != 0 && bad != 0) ? 1 : 0);
  endtask
  initial begin
    repeat (30000) @(posedge mclk_i);
    fail_count++;
    end_of_test();
  end
  initial begin
    rst_b_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 5'h00;
    wdata_i = 32'h0;
    seed = 66474;
    st = 'h180;
    arm = 0;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    rd_stat('h1ff);
    rd(asp_pkg::OFF_OPT, v);
    chk(v, 32'h0);
    wr(5'h18, 16'hffff);
    rd(5'h18, v);
    chk(v, 32'h0);
    wr(asp_pkg::OFF_PIN, 16'h0002);
    repeat (3) @(posedge mclk_i);
    rd(asp_pkg::OFF_PIN, v);
    chk(v, 32'h2);
    wr(asp_pkg::OFF_PIN, 16'h0003);
    repeat (3) @(posedge mclk_i);
    rd(asp_pkg::OFF_PIN, v);
    chk(v, 32'h7);
    wr(asp_pkg::OFF_PIN, 16'h0000);
    wr(asp_pkg::OFF_BAUD, 16'h0001);
    rd(asp_pkg::OFF_BAUD, v);
    chk(v, 32'h1);
    wr(asp_pkg::OFF_OPT, 16'h060c);
    rd(asp_pkg::OFF_OPT, v);
    chk(v, 32'h060c);
    d = 9'($random(seed));
    wr(asp_pkg::OFF_DATA, {7'h00, d});
    asp_remote_inst.grab(f, 10);
    chk(f, {2'h0, 1'b1, ~^d[6:0], d[6:0], 1'b0});
    repeat (32) @(posedge mclk_i);
    st = st | 'h180;
    rx(8, 1, 1, 0, 1);
    e = {7'h00, st[8:0], 7'h00, d};
    rd(asp_pkg::OFF_LONG, v);
    chk(v, e);
    rd_stat('h1ff);
    wr(asp_pkg::OFF_OPT, 16'h060d);
    asp_remote_inst.grab(f, 10);
    chk(f, 32'h0);
    wr(asp_pkg::OFF_OPT, 16'h060c);
    for (int i = 0; i < 16; i++) begin
      wr(asp_pkg::OFF_OPT, 16'(((i & 7) << 8) | 4));
      rx(i[0] ? 9 : 8, i[2], i[1], i[3], 1);
      rd_stat('h7f);
      rd(asp_pkg::OFF_DATA, v);
      chk(v & (i[0] ? 'h1ff : 'hff), {23'h0, d});
      rd_stat('h7f);
    end
    rd_stat('h7f);
    rx(9, 1, 1, 0, 1);
    rd(asp_pkg::OFF_DATA, v);
    chk(v, {23'h0, d});
    rd_stat('h7f);
    rd(asp_pkg::OFF_DATA, v);
    rd_stat('h7f);
    wr(asp_pkg::OFF_OPT, 16'h0700);
    rx(9, 1, 1, 0, 0);
    rd_stat('h7f);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
